//--- hw/lcdm_output_stage.sv
// lcd multiplex output stage: display memory, holding register, drivers
// Summary of operation
// - bypass centre divider impedance for half-bias 1:2
// - holding register stable through each frame
// - drive and bias from mode-setting command fields
// - static drive for single backplane panels
// - 1:2 drive with half or third bias
// - 1:3 drive, normally third bias
// - 1:4 drive, normally third bias
// - 1:3 and 1:4 also accept half bias
// - four backplane outputs follow selected configuration
// - in 1:3 backplane 3 copies backplane 1
// - in 1:2 backplanes 2,3 copy 0,1
// - static: all four backplanes identical
// - top and bottom backplane rows identical
// - 160 segment outputs, one per column
// - segment level from slot and column bits
// - 160 by 4 bit display memory
// - column k to segment k, row r to backplane r
// - stored one drives on, zero drives off
// - reset: 1:4, third bias, disabled, outputs at supply
// - rows 0 to 3 shown in slots 0 to 3
module lcdm_output_stage
  import lcdm_pkg::*;
#(
  parameter int NUM_SEG = 160
)(
  input  wire logic                    CLK_IN,
  input  wire logic                    NRST_IN,
  input  wire logic                    CE_IN,
  input  wire logic                    DISP_TICK_IN,
  input  wire logic                    MODE_LOAD_IN,
  input  wire logic [1:0]              MODE_DRIVE_IN,
  input  wire logic                    MODE_BIAS_IN,
  input  wire logic                    MODE_ENABLE_IN,
  input  wire logic                    RAM_WRITE_IN,
  input  wire logic [7:0]              RAM_COLUMN_IN,
  input  wire logic [ROWS-1:0]         RAM_ROW_MASK_IN,
  input  wire logic [ROWS-1:0]         RAM_DATA_IN,
  input  wire logic [7:0]              RAM_READ_COLUMN_IN,
  output logic      [ROWS-1:0]         RAM_READ_DATA_OUT,
  output logic      [ROWS-1:0][1:0]    BACKPLANE_TOP_OUT,
  output logic      [ROWS-1:0][1:0]    BACKPLANE_BOTTOM_OUT,
  output logic      [NUM_SEG-1:0][1:0] SEGMENT_OUTPUTS_OUT,
  output logic                         BIAS_BYPASS_OUT,
  output logic                         DISPLAY_ACTIVE_OUT,
  output logic      [1:0]              ACTIVE_MODE_OUT,
  output logic                         ACTIVE_BIAS_OUT
);

  // column address is eight bits wide
  if (NUM_SEG < 1 || NUM_SEG > 256) begin : g_bad_num_seg
    $error("lcdm_output_stage: NUM_SEG must be 1 to 256");
  end

  typedef struct packed {
    logic [NUM_SEG-1:0][ROWS-1:0] ram;
    logic [NUM_SEG-1:0][ROWS-1:0] disp;
    logic [1:0]                   mode;
    logic                         bias;
    logic                         en;
    logic [1:0]                   act_mode;
    logic                         act_bias;
    logic                         act_en;
    logic [ROWS-1:0][1:0]         bp;
    logic [NUM_SEG-1:0][1:0]      seg;
    logic                         bypass;
    logic [ROWS-1:0]              rd;
  } lcdm_state_t;

  // reset to 1:4, third bias, disabled
  localparam lcdm_state_t ST_RESET = '{
    ram:      '0,
    disp:     '0,
    mode:     RESET_MODE,
    bias:     RESET_BIAS,
    en:       RESET_ENABLE,
    act_mode: RESET_MODE,
    act_bias: RESET_BIAS,
    act_en:   RESET_ENABLE,
    bp:       {ROWS{LVL_VLCD}},
    seg:      {NUM_SEG{LVL_VLCD}},
    bypass:   1'b0,
    rd:       '0
  };

  lcdm_state_t              st;
  lcdm_state_t              next_st;
  logic [ROWS-1:0][1:0]     bp_lvl;
  logic [NUM_SEG-1:0][1:0]  seg_lvl;
  logic [1:0]               sel_lvl;
  logic [1:0]               idle_lvl;
  logic [1:0]               on_lvl;
  logic [1:0]               off_lvl;
  logic                     third;

  lcdm_slot_if slot_if ();

  // frame timing follows the frozen configuration
  assign slot_if.mode = st.act_mode;
  assign slot_if.run  = st.act_en;

  lcdm_slot_gen u_slot_gen (
    .clk_in  (CLK_IN),
    .nrst_in (NRST_IN),
    .ce_in   (CE_IN),
    .tick_in (DISP_TICK_IN),
    .slot_if (slot_if)
  );

  // static uses only full levels; half bias adds the mid level for idle backplanes
  // third bias adds the two inner levels
  // half bias allowed in every multiplexed mode
  assign third = (st.act_bias == BIAS_THIRD) && (st.act_mode != MODE_STATIC);

  // levels swap sides on the inverted half
  assign sel_lvl  = slot_if.pol ? LVL_VSS : LVL_VLCD;
  assign on_lvl   = slot_if.pol ? LVL_VLCD : LVL_VSS;
  assign off_lvl  = third ? (slot_if.pol ? LVL_LO : LVL_HI) : sel_lvl;
  assign idle_lvl = third ? (slot_if.pol ? LVL_HI : LVL_LO) : LVL_LO;

  for (genvar r = 0; r < ROWS; r++) begin : g_bp
    // selected in its own slot, idle otherwise
    assign bp_lvl[r] = !st.act_en ? LVL_VLCD :
      (slot_if.slot == plane_source(st.act_mode, 2'(r))) ? sel_lvl :
      idle_lvl;
  end

  for (genvar k = 0; k < NUM_SEG; k++) begin : g_seg
    // column bit of the current slot row
    // one gives on level, zero off level
    assign seg_lvl[k] = !st.act_en ? LVL_VLCD :
      st.disp[k][slot_if.slot] ? on_lvl : off_lvl;
  end

  always_comb begin
    next_st = st;
    // configuration taken from the command fields
    if (MODE_LOAD_IN) begin
      next_st.mode = MODE_DRIVE_IN;
      next_st.bias = MODE_BIAS_IN;
      next_st.en   = MODE_ENABLE_IN;
    end
    if (RAM_WRITE_IN && (32'(RAM_COLUMN_IN) < NUM_SEG)) begin
      next_st.ram[RAM_COLUMN_IN] = (st.ram[RAM_COLUMN_IN] & ~RAM_ROW_MASK_IN)
                                 | (RAM_DATA_IN & RAM_ROW_MASK_IN);
    end
    if (32'(RAM_READ_COLUMN_IN) < NUM_SEG) begin
      next_st.rd = st.ram[RAM_READ_COLUMN_IN];
    end else begin
      next_st.rd = '0;
    end
    // image and mode frozen for a whole frame
    if (slot_if.frame_start) begin
      next_st.disp     = st.ram;
      next_st.act_mode = st.mode;
      next_st.act_bias = st.bias;
      next_st.act_en   = st.en;
    end
    next_st.bp  = bp_lvl;
    next_st.seg = seg_lvl;
    // centre impedance shorted only for half-bias 1:2
    next_st.bypass = (st.act_bias == BIAS_HALF) && (st.act_mode == MODE_X2);
  end

  always_ff @(posedge CLK_IN) begin
    if (!NRST_IN) begin
      st <= ST_RESET;
    end else if (CE_IN) begin
      st <= next_st;
    end
  end

  // both pin rows from one register
  assign BACKPLANE_TOP_OUT    = st.bp;
  assign BACKPLANE_BOTTOM_OUT = st.bp;
  assign SEGMENT_OUTPUTS_OUT  = st.seg;
  assign BIAS_BYPASS_OUT      = st.bypass;
  assign DISPLAY_ACTIVE_OUT   = st.act_en;
  assign ACTIVE_MODE_OUT      = st.act_mode;
  assign ACTIVE_BIAS_OUT      = st.act_bias;
  assign RAM_READ_DATA_OUT    = st.rd;

endmodule : lcdm_output_stage

//--- hw/lcdm_pkg.sv
// shared constants, encodings and helpers of the lcd multiplex output stage
package lcdm_pkg;

  localparam int ROWS             = 4;
  // one frame is 24 display clock ticks, split into two polarity halves
  localparam int FRAME_TICKS      = 24;
  localparam int HALF_FRAME_TICKS = FRAME_TICKS / 2;

  // drive configuration field of the mode-setting command
  localparam logic [1:0] MODE_X4     = 2'h0;
  localparam logic [1:0] MODE_STATIC = 2'h1;
  localparam logic [1:0] MODE_X2     = 2'h2;
  localparam logic [1:0] MODE_X3     = 2'h3;

  // bias field of the mode-setting command
  localparam logic BIAS_THIRD = 1'b0;
  localparam logic BIAS_HALF  = 1'b1;

  // output level codes; under half bias LVL_LO stands for the mid level
  localparam logic [1:0] LVL_VSS  = 2'h0;
  localparam logic [1:0] LVL_LO   = 2'h1;
  localparam logic [1:0] LVL_HI   = 2'h2;
  localparam logic [1:0] LVL_VLCD = 2'h3;

  localparam logic [1:0] RESET_MODE   = MODE_X4;
  localparam logic       RESET_BIAS   = BIAS_THIRD;
  localparam logic       RESET_ENABLE = 1'b0;

  localparam logic [3:0] SLOT_TICKS_STATIC = 4'(HALF_FRAME_TICKS / 1);
  localparam logic [3:0] SLOT_TICKS_X2     = 4'(HALF_FRAME_TICKS / 2);
  localparam logic [3:0] SLOT_TICKS_X3     = 4'(HALF_FRAME_TICKS / 3);
  localparam logic [3:0] SLOT_TICKS_X4     = 4'(HALF_FRAME_TICKS / 4);

  // number of active backplanes for a drive configuration
  function automatic logic [2:0] mode_planes(input logic [1:0] m);
    logic [2:0] n;
    n = 3'h4;
    unique case (m)
      MODE_STATIC: n = 3'h1;
      MODE_X2:     n = 3'h2;
      MODE_X3:     n = 3'h3;
      MODE_X4:     n = 3'h4;
    endcase
    return n;
  endfunction : mode_planes

  // display clock ticks per backplane time slot
  function automatic logic [3:0] slot_ticks(input logic [1:0] m);
    logic [3:0] t;
    t = SLOT_TICKS_X4;
    unique case (m)
      MODE_STATIC: t = SLOT_TICKS_STATIC;
      MODE_X2:     t = SLOT_TICKS_X2;
      MODE_X3:     t = SLOT_TICKS_X3;
      MODE_X4:     t = SLOT_TICKS_X4;
    endcase
    return t;
  endfunction : slot_ticks

  // time slot in which backplane output r is the selected one
  function automatic logic [1:0] plane_source(input logic [1:0] m,
                                              input logic [1:0] r);
    logic [1:0] s;
    s = r;
    unique case (m)
      MODE_STATIC: s = 2'h0;
      MODE_X2:     s = {1'b0, r[0]};
      MODE_X3:     s = (r == 2'h3) ? 2'h1 : r;
      MODE_X4:     s = r;
    endcase
    return s;
  endfunction : plane_source

endpackage : lcdm_pkg

//--- hw/lcdm_slot_gen.sv
// backplane time slot and polarity sequencer
module lcdm_slot_gen
  import lcdm_pkg::*;
(
  input  wire logic  clk_in,
  input  wire logic  nrst_in,
  input  wire logic  ce_in,
  input  wire logic  tick_in,
  lcdm_slot_if.gen   slot_if
);

  typedef struct packed {
    logic [3:0] cnt;
    logic [1:0] slot;
    logic       pol;
  } lcdm_gen_state_t;

  lcdm_gen_state_t st;
  lcdm_gen_state_t next_st;
  logic            last_slot;
  logic            end_slot;

  // slots per plane, polarity per half
  always_comb begin
    next_st   = st;
    last_slot = {1'b0, st.slot} == (mode_planes(slot_if.mode) - 3'h1);
    end_slot  = tick_in && (st.cnt == (slot_ticks(slot_if.mode) - 4'h1));
    if (!slot_if.run) begin
      next_st = '0;
    end else if (end_slot) begin
      next_st.cnt = '0;
      if (last_slot) begin
        next_st.slot = '0;
        next_st.pol  = ~st.pol;
      end else begin
        next_st.slot = st.slot + 2'h1;
      end
    end else if (tick_in) begin
      next_st.cnt = st.cnt + 4'h1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      st <= '0;
    end else if (ce_in) begin
      st <= next_st;
    end
  end

  assign slot_if.slot = st.slot;
  assign slot_if.pol  = st.pol;
  // while running, a new frame begins only after a whole, balanced pair of halves; while stopped, every cycle
  assign slot_if.frame_start = !slot_if.run ||
                               (end_slot && last_slot && st.pol);

endmodule : lcdm_slot_gen

//--- hw/lcdm_slot_if.sv
// slot timing carrier between the output stage and its slot generator
interface lcdm_slot_if;
  logic [1:0] mode;
  logic       run;
  logic [1:0] slot;
  logic       pol;
  logic       frame_start;

  modport ctrl (output mode, output run,
                input slot, input pol, input frame_start);
  modport gen  (input mode, input run,
                output slot, output pol, output frame_start);
endinterface : lcdm_slot_if

//--- verif/lcdm_output_stage_sva.sv
// port checker of the lcd multiplex output stage
module lcdm_output_stage_sva
  import lcdm_pkg::*;
#(parameter int NUM_SEG = 160)(
  input wire logic                    CLK_IN,
  input wire logic                    NRST_IN,
  input wire logic                    CE_IN,
  input wire logic                    RAM_WRITE_IN,
  input wire logic [7:0]              RAM_COLUMN_IN,
  input wire logic [ROWS-1:0]         RAM_ROW_MASK_IN,
  input wire logic [ROWS-1:0]         RAM_DATA_IN,
  input wire logic [7:0]              RAM_READ_COLUMN_IN,
  input wire logic [ROWS-1:0]         RAM_READ_DATA_OUT,
  input wire logic [ROWS-1:0][1:0]    BACKPLANE_TOP_OUT,
  input wire logic [ROWS-1:0][1:0]    BACKPLANE_BOTTOM_OUT,
  input wire logic [NUM_SEG-1:0][1:0] SEGMENT_OUTPUTS_OUT,
  input wire logic                    BIAS_BYPASS_OUT,
  input wire logic                    DISPLAY_ACTIVE_OUT,
  input wire logic [1:0]              ACTIVE_MODE_OUT
);
  logic [ROWS-1:0][1:0] bp;
  logic [ROWS-1:0]      ext;
  assign bp = BACKPLANE_TOP_OUT;
  // outputs lag the frozen config by one edge, hence the $past terms
  always_comb begin
    for (int r = 0; r < ROWS; r++) begin
      ext[r] = bp[r] inside {LVL_VSS, LVL_VLCD};
    end
  end
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!NRST_IN);
  a_rows_same: assert property (bp == BACKPLANE_BOTTOM_OUT)
    else $error("backplane rows differ");
  a_static_same: assert property ($past(ACTIVE_MODE_OUT) == MODE_STATIC
    |-> bp == {ROWS{bp[0]}}) else $error("static backplanes differ");
  a_x3_pair: assert property ($past(ACTIVE_MODE_OUT) == MODE_X3
    |-> bp[3] == bp[1]) else $error("1:3 backplane 3 not backplane 1");
  a_x2_pair: assert property ($past(ACTIVE_MODE_OUT) == MODE_X2
    |-> bp[2] == bp[0] && bp[3] == bp[1]) else $error("1:2 pairs differ");
  a_reset_levels: assert property (disable iff (1'b0) !NRST_IN |=>
    bp == '1 && SEGMENT_OUTPUTS_OUT == '1 && !DISPLAY_ACTIVE_OUT
    && ACTIVE_MODE_OUT == MODE_X4) else $error("reset state wrong");
  a_idle_supply: assert property (!$past(DISPLAY_ACTIVE_OUT)
    |-> bp == '1 && SEGMENT_OUTPUTS_OUT == '1) else $error("idle not supply");
  a_one_slot: assert property ($past(DISPLAY_ACTIVE_OUT)
    && $past(ACTIVE_MODE_OUT) == MODE_X4 |-> $onehot(ext))
    else $error("not one selected backplane");
  a_read_back: assert property (RAM_WRITE_IN && CE_IN
    && RAM_ROW_MASK_IN == 4'hF && RAM_COLUMN_IN < NUM_SEG ##1
    RAM_READ_COLUMN_IN == $past(RAM_COLUMN_IN) && !RAM_WRITE_IN && CE_IN
    |=> RAM_READ_DATA_OUT == $past(RAM_DATA_IN, 2)) else $error("readback");
  c_static: cover property (DISPLAY_ACTIVE_OUT
    && ACTIVE_MODE_OUT == MODE_STATIC);
  c_x3: cover property (DISPLAY_ACTIVE_OUT && ACTIVE_MODE_OUT == MODE_X3);
  c_bypass: cover property (BIAS_BYPASS_OUT);
endmodule : lcdm_output_stage_sva

bind lcdm_output_stage lcdm_output_stage_sva #(.NUM_SEG(NUM_SEG)) chk_u (.*);

//--- verif/lcdm_output_stage_test.sv
// self-checking bench of the lcd multiplex output stage
module lcdm_output_stage_test
  import lcdm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, nrst = 1'b0, load = 1'b0, bias = 1'b0, en = 1'b0;
  logic wr = 1'b0, byp, act, abias;
  logic [1:0] drv = 2'h0, amode;
  logic [7:0] col = 8'h00, rcol = 8'h00;
  logic [3:0] mask = 4'h0, data = 4'h0, rdata, seen;
  logic [3:0][1:0] bpt, bpb;
  logic [159:0][1:0] seg;
  logic clr = 1'b0;
  int failures = 0, n_checks = 0;
  always #2 clk = ~clk;
  lcdm_output_stage dut_u (.CLK_IN(clk), .NRST_IN(nrst), .CE_IN(1'b1),
    .DISP_TICK_IN(1'b1), .MODE_LOAD_IN(load), .MODE_DRIVE_IN(drv),
    .MODE_BIAS_IN(bias), .MODE_ENABLE_IN(en), .RAM_WRITE_IN(wr),
    .RAM_COLUMN_IN(col), .RAM_ROW_MASK_IN(mask), .RAM_DATA_IN(data),
    .RAM_READ_COLUMN_IN(rcol), .RAM_READ_DATA_OUT(rdata),
    .BACKPLANE_TOP_OUT(bpt), .BACKPLANE_BOTTOM_OUT(bpb),
    .SEGMENT_OUTPUTS_OUT(seg), .BIAS_BYPASS_OUT(byp),
    .DISPLAY_ACTIVE_OUT(act), .ACTIVE_MODE_OUT(amode),
    .ACTIVE_BIAS_OUT(abias));
  lcdm_panel_model panel_u (.clk_in(clk), .clr_in(clr), .bp_in(bpt),
    .seg_in(seg[7]), .on_seen_out(seen));
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic set_mode(logic [1:0] m, logic b, logic e);
    int i;
    @(posedge clk);
    load <= 1'b1;
    drv <= m;
    bias <= b;
    en <= e;
    @(posedge clk);
    load <= 1'b0;
    // a running frame must finish first; a bias-only change leaves mode
    // and enable as they were, so always let one whole frame pass
    repeat (FRAME_TICKS + 2) @(negedge clk);
    // a running frame must finish first, so allow several frames
    for (i = 0; i < 80 && !(amode === m && act === e); i++)
      @(negedge clk);
    if (i == 80) begin
      failures++;
      conclude();
    end
  endtask : set_mode
  task automatic write(logic [7:0] c, logic [3:0] m, logic [3:0] d);
    @(posedge clk);
    wr <= 1'b1;
    col <= c;
    rcol <= c;
    mask <= m;
    data <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : write
  task automatic read(logic [7:0] c, logic [3:0] exp);
    @(posedge clk);
    rcol <= c;
    @(posedge clk);
    @(negedge clk);
    chk("ram", 8'(exp), 8'(rdata));
  endtask : read
  task automatic t_ram;
    write(8'h9F, 4'hF, 4'h9);
    write(8'h9F, 4'h2, 4'hF);
    write(8'hA0, 4'hF, 4'hF);
    read(8'h9F, 4'hB);
    read(8'hA0, 4'h0);
  endtask : t_ram
  task automatic t_modes;
    for (int k = 0; k < 8; k++) begin
      set_mode(k[2:1], k[0], 1'b1);
      repeat (2) @(negedge clk);
      chk("bypass", 8'(k[0] && k[2:1] == MODE_X2), 8'(byp));
      if (k[2:1] != MODE_STATIC)
        chk("bias", 8'(k[0]), 8'(abias));
    end
  endtask : t_modes
  task automatic t_image;
    logic [1:0] ms [3] = '{MODE_X4, MODE_X2, MODE_X3};
    logic [3:0] ex [3] = '{4'h6, 4'hA, 4'hE};
    write(8'h07, 4'hF, 4'h6);
    for (int i = 0; i < 3; i++) begin
      set_mode(ms[i], BIAS_THIRD, 1'b1);
      // one frame is 24 ticks; pass one for reload, watch the next
      repeat (26) @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      repeat (24) @(negedge clk);
      chk("image", 8'(ex[i]), 8'(seen));
    end
  endtask : t_image
  initial begin
    repeat (20) @(posedge clk);
    @(negedge clk);
    chk("reset bp", 8'hFF, bpt);
    chk("reset mode", 8'(MODE_X4), 8'(amode));
    chk("reset act", 8'h00, 8'(act));
    @(posedge clk);
    nrst <= 1'b1;
    t_ram();
    t_modes();
    t_image();
    set_mode(MODE_X4, BIAS_THIRD, 1'b0);
    repeat (2) @(negedge clk);
    chk("idle bp", 8'hFF, bpb);
    conclude();
  end
endmodule : lcdm_output_stage_test

//--- verif/lcdm_panel_model.sv
// passive panel model: flags elements of one segment column seen on
module lcdm_panel_model
  import lcdm_pkg::*;
(
  input  wire logic                 clk_in,
  input  wire logic                 clr_in,
  input  wire logic [ROWS-1:0][1:0] bp_in,
  input  wire logic [1:0]           seg_in,
  output logic      [ROWS-1:0]      on_seen_out
);
  // only the full supply across an element turns it on; bias steps do not
  always_ff @(posedge clk_in) begin
    for (int r = 0; r < ROWS; r++) begin
      if (clr_in)
        on_seen_out[r] <= 1'b0;
      else if (bp_in[r] == ~seg_in && bp_in[r] inside {LVL_VSS, LVL_VLCD})
        on_seen_out[r] <= 1'b1;
    end
  end
endmodule : lcdm_panel_model
